//--- sts_pkg.sv
// constants, instruction codes and state type for the self-test sequencer
package sts_pkg;
  // engine and chain geometry
  localparam int unsigned NUM_ENG        = 8;            // engines, cores and tag slices
  localparam int unsigned SEG_W          = 8;            // bits per shadow segment
  localparam int unsigned CHAIN_W        = 64;           // full shadow data width
  localparam int unsigned INSTR_W        = 8;            // instruction width
  localparam int unsigned TIMEOUT_W      = 32;           // timeout counter width
  // instruction codes seen on the instruction bus
  localparam logic [7:0]  INSTR_START    = 8'h10;        // begin sequencing
  localparam logic [7:0]  INSTR_ABORT    = 8'h11;        // stop sequencing
  localparam logic [7:0]  INSTR_SKIP     = 8'h12;        // skip mask access
  localparam logic [7:0]  INSTR_MODE     = 8'h13;        // run select access
  localparam logic [7:0]  INSTR_DONE_RD  = 8'h14;        // completion_read_instr
  localparam logic [7:0]  INSTR_THREAD0  = 8'h20;        // thread_shadow_capture_instr, thread 0
  localparam logic [4:0]  INSTR_THR_HI   = 5'h04;        // upper bits shared by the eight thread codes
  localparam logic [7:0]  INSTR_TAG      = 8'h28;        // tag_shadow_capture_instr
  localparam logic [7:0]  INSTR_DIAG     = 8'h30;        // array_test_diag_instr
  localparam logic [7:0]  INSTR_SERIAL   = 8'h31;        // serial_chain_instr
  // run select field layout
  localparam int unsigned MODE_PAR_BIT   = 0;            // 1 parallel, 0 serial
  localparam int unsigned MODE_PROG_BIT  = 1;            // program access mode
  // reset values
  localparam logic [7:0]  SKIP_RESET     = 8'h00;        // all engines take part
  localparam logic [1:0]  MODE_RESET     = 2'h1;         // parallel by default
  localparam logic [31:0] TIMEOUT_DFLT   = 32'hFFFFFFFF; // full 32-bit timeout
  // sequencer states
  typedef enum logic [0:0] {
    STS_IDLE,
    STS_RUN
  } sts_state_type;
endpackage : sts_pkg

//--- sts_sequencer.sv
// self-test sequencer with jtag register access and shadow-scan chains
`timescale 1ns/1ps
`default_nettype none
// Function
// - go held until engine reports finished
// - parallel mode starts all engines together
// - serial mode starts engines lowest first
// - go held until all engines finished
// - drive manufacturing scan control to engines
// - 8-bit skip mask excludes engines
// - run select: bit0 parallel, bit1 program
// - completion flags, one per finished engine
// - instructions start and stop sequencing
// - array-init pass after power phase, timed
// - complete on all finished or timeout
// - power pass honours skip mask
// - power pass uses only parallel/serial bit
// - software run between warm phases
// - skip engines in unavailable/disabled cores
// - shadow chains read-only, shifted data lost
// - core chain: core 0 near input
// - unavailable cores left out of chain
// - tag slices captured together, 0 first
// - thread and tag shadow instructions
// - diag chain keeps core scan enable
module sts_sequencer
  import sts_pkg::*;
#(
  parameter logic [31:0] TIMEOUT_CYCLES = TIMEOUT_DFLT     // reset-run timeout
) (
  input  wire logic              core_clk,         // cpu clock, 200 MHz
  input  wire logic              nrst,             // synchronous reset, active low
  input  wire logic              jtagTck,          // test clock pin
  input  wire logic              jtagTdi,          // test data in pin
  input  wire logic [7:0]        jtagInstr,        // current instruction from tap
  input  wire logic              jtagCaptureDr,    // tap in capture-dr
  input  wire logic              jtagShiftDr,      // tap in shift-dr
  input  wire logic              jtagUpdateDr,     // tap in update-dr
  input  wire logic              mfgScanMode,      // manufacturing scan pin
  output logic                   jtagTdo,          // test data out
  output logic [7:0]             engineGo,         // go per engine
  input  wire logic [7:0]        engineFinished,   // finished per engine
  output logic                   engineTestMode,   // scan control to all engines
  input  wire logic [7:0]        coreAvail,        // core available flags
  input  wire logic [7:0]        coreDisable,      // core or bank disabled flags
  input  wire logic              firstPowerDone,   // first_power_reset_phase ended
  input  wire logic              warmPhaseOne,     // warm_reset_phase_one active
  input  wire logic              swRunReq,         // software asked for a run
  input  wire logic              swArrayInit,      // software run is array_init_run
  output logic                   selfTestComplete, // to reset unit
  output logic                   runArrayInit,     // current run is an array-init pass
  output logic                   progAccess,       // program access mode
  output logic [2:0]             shadowThreadSel,  // thread picked for core capture
  input  wire logic [63:0]       coreShadowData,   // core capture data, core c at c*8
  input  wire logic [63:0]       tagShadowData,    // tag capture data, slice s at s*8
  output logic [7:0]             coreScanEnable,   // scan enable to whole cores
  output logic                   diagChainSel      // short diag chain selected
);

  // lowest set bit of a mask
  function automatic logic [7:0] lowestBit(input logic [7:0] m);
    lowestBit = m & (~m + 8'h01);
  endfunction : lowestBit

  // two-flop synchronisers for everything from the jtag side
  logic       tckS1, tckS2, tckS3;         // test clock stages
  logic       tdiS1, tdiS2;                // data in stages
  logic [7:0] instrS1, instrS2;            // instruction stages
  logic       capS1, capS2;                // capture stages
  logic       shS1, shS2;                  // shift stages
  logic       updS1, updS2;                // update stages
  logic       mfgS1, mfgS2;                // scan mode stages

  // synchroniser registers
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      {tckS1, tckS2, tckS3} <= 3'h0;
      {tdiS1, tdiS2}        <= 2'h0;
      {instrS1, instrS2}    <= 16'h0000;
      {capS1, capS2}        <= 2'h0;
      {shS1, shS2}          <= 2'h0;
      {updS1, updS2}        <= 2'h0;
      {mfgS1, mfgS2}        <= 2'h0;
    end else begin
      {tckS1, tckS2, tckS3} <= {jtagTck, tckS1, tckS2};
      {tdiS1, tdiS2}        <= {jtagTdi, tdiS1};
      {instrS1, instrS2}    <= {jtagInstr, instrS1};
      {capS1, capS2}        <= {jtagCaptureDr, capS1};
      {shS1, shS2}          <= {jtagShiftDr, shS1};
      {updS1, updS2}        <= {jtagUpdateDr, updS1};
      {mfgS1, mfgS2}        <= {mfgScanMode, mfgS1};
    end
  end

  // test clock edge and tap actions
  wire tckRise  = tckS2 & ~tckS3;          // rising test clock
  wire doCap    = tckRise & capS2;         // capture step
  wire doShift  = tckRise & shS2;          // shift step
  wire doUpd    = tckRise & updS2;         // update step

  // instruction decode
  wire isStart  = (instrS2 == INSTR_START);
  wire isAbort  = (instrS2 == INSTR_ABORT);
  wire isSkip   = (instrS2 == INSTR_SKIP);
  wire isMode   = (instrS2 == INSTR_MODE);
  wire isDoneRd = (instrS2 == INSTR_DONE_RD);
  wire isThread = (instrS2[7:3] == INSTR_THR_HI);
  wire isTag    = (instrS2 == INSTR_TAG);
  wire isDiag   = (instrS2 == INSTR_DIAG);
  wire isSerial = (instrS2 == INSTR_SERIAL);
  wire isShortDr = isSkip | isMode | isDoneRd;

  // register file state
  logic [7:0]    skipMask;                 // lbist_engine_skip_mask
  logic [1:0]    runSelect;                // lbist_run_select
  logic [7:0]    doneFlags;                // lbist_completion_flags
  logic [7:0]    dr;                       // shared short data register
  logic [7:0]    activeMask;               // engines in the current run
  logic [31:0]   timer;                    // reset-run timeout count
  logic          fromReset;                // run started by reset sequence
  logic          warmPending;              // software run awaiting service
  logic          warmOneDly;               // previous warm phase one level
  logic          powerDly;                 // previous power phase level
  sts_state_type state;                    // sequencer state

  // engine selection and completion
  wire [7:0] engineAvail = coreAvail & ~coreDisable;
  wire [7:0] nextActive  = ~(skipMask | ~engineAvail);
  wire [7:0] finishedNow = doneFlags | (engineFinished & engineGo);
  wire       allDone     = ((finishedNow & activeMask) == activeMask);
  wire       startedDone = ((finishedNow & engineGo) == engineGo);
  wire [7:0] serialNext  = lowestBit(activeMask & ~engineGo);
  wire       timedOut    = fromReset & (timer == TIMEOUT_CYCLES - 32'h1);
  wire       parMode     = runSelect[MODE_PAR_BIT];

  // run triggers
  wire jtagStart = doUpd & isStart;
  wire abortNow  = doUpd & isAbort;
  wire powerRise = firstPowerDone & ~powerDly;
  wire warmRise  = warmPhaseOne & ~warmOneDly;
  wire warmStart = warmPending & warmPhaseOne;
  wire startRun  = (state == STS_IDLE) & ~abortNow & (jtagStart | powerRise | warmStart);
  wire endRun    = (state == STS_RUN) & (abortNow | allDone | timedOut);

  // first go pattern of a run
  wire [7:0] firstGo = parMode ? nextActive : lowestBit(nextActive);

  // sequencer state and go signals
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      state      <= STS_IDLE;
      engineGo   <= 8'h00;
      activeMask <= 8'h00;
    end else begin
      case (state)
        STS_IDLE: begin
          // start a run with the chosen engines
          if (startRun) begin
            state      <= STS_RUN;
            engineGo   <= firstGo;
            activeMask <= nextActive;
          end
        end
        STS_RUN: begin
          if (endRun) begin
            // all finished, timed out or aborted
            state    <= STS_IDLE;
            engineGo <= 8'h00;
          end else if (!parMode && startedDone) begin
            // serial: add the next engine, keep earlier ones
            engineGo <= engineGo | serialNext;
          end
        end
        default: state <= STS_IDLE;
      endcase
    end
  end

  // completion flags, timer and reset handshake
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      doneFlags        <= 8'h00;
      timer            <= 32'h0;
      fromReset        <= 1'b0;
      selfTestComplete <= 1'b0;
      runArrayInit     <= 1'b0;
    end else if (startRun) begin
      // clear the record of the previous run
      doneFlags        <= 8'h00;
      timer            <= 32'h0;
      fromReset        <= powerRise | warmStart;
      selfTestComplete <= 1'b0;
      runArrayInit     <= powerRise | (warmStart & swArrayInit);
    end else if (state == STS_RUN) begin
      doneFlags <= finishedNow;
      timer     <= timer + 32'h1;
      // tell the reset unit when a reset run ends
      if (endRun && fromReset) begin
        selfTestComplete <= 1'b1;
      end
    end
  end

  // reset sequence tracking
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      powerDly    <= 1'b0;
      warmOneDly  <= 1'b0;
      warmPending <= 1'b0;
    end else begin
      powerDly   <= firstPowerDone;
      warmOneDly <= warmPhaseOne;
      // note the request at warm phase one, serve it before phase two
      if (warmRise && swRunReq) begin
        warmPending <= 1'b1;
      end else if (warmStart && state == STS_IDLE) begin
        warmPending <= 1'b0;
      end
    end
  end

  // short data register and the stored settings
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      dr        <= 8'h00;
      skipMask  <= SKIP_RESET;
      runSelect <= MODE_RESET;
    end else if (doCap && isShortDr) begin
      // load the selected register for reading
      if (isSkip) begin
        dr <= skipMask;
      end else if (isMode) begin
        dr <= {6'h00, runSelect};
      end else begin
        dr <= doneFlags;
      end
    end else if (doShift && isShortDr) begin
      dr <= {tdiS2, dr[7:1]};
    end else if (doUpd && isSkip) begin
      skipMask <= dr;
    end else if (doUpd && isMode) begin
      runSelect <= dr[1:0];
    end
  end

  // core shadow chain links, skipping unavailable cores
  logic [SEG_W-1:0] coreSeg [NUM_ENG];     // per-core shadow segments
  logic [7:0]       segIn;                 // bit entering each segment
  logic [7:0]       segOut;                // bit leaving each position
  logic             chainLink;             // bit handed on to the next core
  always_comb begin
    segIn     = 8'h00;
    segOut    = 8'h00;
    chainLink = tdiS2;
    for (int c = 0; c < NUM_ENG; c++) begin
      segIn[c]  = chainLink;
      segOut[c] = coreAvail[c] ? coreSeg[c][0] : chainLink;
      chainLink = segOut[c];
    end
  end

  // core shadow segments: capture, then shift only
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      for (int c = 0; c < NUM_ENG; c++) coreSeg[c] <= '0;
    end else if (doCap && isThread) begin
      for (int c = 0; c < NUM_ENG; c++) coreSeg[c] <= coreShadowData[c*SEG_W +: SEG_W];
    end else if (doShift && isThread) begin
      for (int c = 0; c < NUM_ENG; c++) begin
        if (coreAvail[c]) coreSeg[c] <= {segIn[c], coreSeg[c][SEG_W-1:1]};
      end
    end
  end

  // tag shadow chain, slice 0 leaves first
  logic [CHAIN_W-1:0] tagChain;            // all tag slices
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      tagChain <= '0;
    end else if (doCap && isTag) begin
      tagChain <= tagShadowData;
    end else if (doShift && isTag) begin
      tagChain <= {tdiS2, tagChain[CHAIN_W-1:1]};
    end
  end

  // data out selection
  wire tdoNext = isThread ? segOut[7] :
                 isTag    ? tagChain[0] :
                 isShortDr ? dr[0] : tdiS2;

  // registered outputs to pins and engines
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      jtagTdo         <= 1'b0;
      engineTestMode  <= 1'b0;
      progAccess      <= 1'b0;
      shadowThreadSel <= 3'h0;
      coreScanEnable  <= 8'h00;
      diagChainSel    <= 1'b0;
    end else begin
      jtagTdo         <= tdoNext;
      engineTestMode  <= mfgS2;
      progAccess      <= runSelect[MODE_PROG_BIT];
      shadowThreadSel <= isThread ? instrS2[2:0] : shadowThreadSel;
      coreScanEnable  <= {8{shS2 & (isDiag | isSerial)}};
      diagChainSel    <= isDiag;
    end
  end

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  sequence runBegin;
    startRun;
  endsequence
  sequence runHeld;
    (state == STS_RUN) && !endRun;
  endsequence

  go_hold_a: assert property (runHeld |=> ((engineGo & $past(engineGo)) == $past(engineGo)))
    else $error("go dropped before run ended");
  par_start_a: assert property (runBegin ##0 parMode |=> engineGo == $past(nextActive))
    else $error("parallel start mismatch");
  ser_first_a: assert property (runBegin ##0 !parMode |=> engineGo == lowestBit($past(nextActive)))
    else $error("serial start mismatch");
  all_held_a: assert property (runHeld ##0 !allDone |=> engineGo != 8'h00 || activeMask == 8'h00)
    else $error("go released early");
  scan_mode_a: assert property (mfgS2 |=> engineTestMode)
    else $error("scan control not driven");
  skip_write_a: assert property (doUpd && isSkip |=> skipMask == $past(dr))
    else $error("skip mask not written");
  done_seen_a: assert property ((state == STS_RUN) && (engineFinished[0] & engineGo[0]) && !startRun |=> doneFlags[0])
    else $error("completion flag missed");
  abort_idle_a: assert property (abortNow && state == STS_RUN |=> state == STS_IDLE && engineGo == 8'h00)
    else $error("abort did not stop");
  timeout_a: assert property ((state == STS_RUN) && timedOut |=> selfTestComplete)
    else $error("timeout not reported");
  tag_cap_a: assert property (doCap && isTag |=> tagChain == $past(tagShadowData))
    else $error("tag capture wrong");
  skip_out_a: assert property (runBegin |=> (engineGo & ~$past(nextActive)) == 8'h00)
    else $error("skipped engine started");

endmodule : sts_sequencer
`default_nettype wire

//--- sts_engine_model.sv
// behavioural model of the eight self-test engines
`timescale 1ns/1ps
`default_nettype none
module sts_engine_model
  import sts_pkg::*;
(
  input  wire logic        core_clk,      // cpu clock
  input  wire logic        nrst,          // sync reset, active low
  input  wire logic [7:0]  engineGo,      // go per engine
  input  wire logic [7:0]  stuck,         // engines that never finish
  input  wire logic [31:0] seed,          // delay per engine, 4 bits each
  output logic [7:0]       engineFinished // finished per engine
);
  logic [3:0] waitCnt [8]; // cycles left per engine
  // finish after a delay of 0..15, held while go stays high
  always_ff @(posedge core_clk) begin
    for (int e = 0; e < 8; e++) begin
      if (!nrst || !engineGo[e]) begin
        waitCnt[e]        <= seed[e*4+:4];
        engineFinished[e] <= 1'b0;
      end else if (waitCnt[e] != 4'h0) begin
        waitCnt[e] <= waitCnt[e] - 4'h1;
      end else begin
        engineFinished[e] <= !stuck[e];
      end
    end
  end
endmodule : sts_engine_model
`default_nettype wire

//--- selftest_sequencer_shadow_scan_tb.sv
// self-checking bench for the self-test sequencer
`timescale 1ns/1ps
`default_nettype none
module selftest_sequencer_shadow_scan_tb
  import sts_pkg::*;
;
  logic        core_clk, nrst, jtagTck, jtagTdi, jtagTdo;   // clock, reset, test pins
  logic        jtagCaptureDr, jtagShiftDr, jtagUpdateDr;   // tap state levels
  logic        mfgScanMode, engineTestMode, selfTestComplete; // scan and done
  logic        firstPowerDone, warmPhaseOne, swRunReq, swArrayInit; // reset phases
  logic        runArrayInit, progAccess, diagChainSel;     // status outputs
  logic [2:0]  shadowThreadSel;                            // thread picked
  logic [7:0]  jtagInstr, coreAvail, coreDisable, stuck;   // stimulus
  logic [7:0]  engineGo, engineFinished, coreScanEnable;   // engine side
  logic [31:0] rnd, dly;                                   // random state
  logic [63:0] coreShadowData, tagShadowData, got;         // shadow data
  int          nFail = 0, nChecks = 0;                     // counters

  sts_sequencer #(.TIMEOUT_CYCLES(32'd40)) dut (.core_clk, .nrst, .jtagTck, .jtagTdi,
    .jtagInstr, .jtagCaptureDr, .jtagShiftDr, .jtagUpdateDr, .mfgScanMode, .jtagTdo,
    .engineGo, .engineFinished, .engineTestMode, .coreAvail, .coreDisable,
    .firstPowerDone, .warmPhaseOne, .swRunReq, .swArrayInit, .selfTestComplete,
    .runArrayInit, .progAccess, .shadowThreadSel, .coreShadowData, .tagShadowData,
    .coreScanEnable, .diagChainSel);
  sts_engine_model eng (.core_clk, .nrst, .engineGo, .stuck, .seed(dly), .engineFinished);

  // 200 MHz clock
  always #2.5 core_clk = ~core_clk;

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs

  // core chain stream: core 7 leaves first, unavailable cores dropped
  function automatic logic [63:0] coreStream(input logic [7:0] av, input logic [63:0] d);
    logic [63:0] s;
    int          k;
    s = '0;
    k = 0;
    for (int c = 7; c >= 0; c--) begin
      if (av[c]) begin
        s[k*8+:8] = d[c*8+:8];
        k++;
      end
    end
    return s;
  endfunction : coreStream

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick

  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    nChecks++;
    if (g !== e) begin
      nFail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // one tck period of 125 ns, tdo sampled late in the low phase
  task automatic tckBit(input logic c, input logic s, input logic u, input logic d, output logic o);
    jtagCaptureDr <= c;
    jtagShiftDr   <= s;
    jtagUpdateDr  <= u;
    jtagTdi       <= d;
    jtagTck       <= 1'b0;
    tick(12);
    o = jtagTdo;
    jtagTck <= 1'b1;
    tick(13);
  endtask : tckBit

  // capture, n shifts lsb first, update
  task automatic dr(input logic [7:0] ins, input int n, input logic [63:0] din, output logic [63:0] dout);
    logic o;
    dout = '0;
    jtagInstr <= ins;
    tick(4);
    tckBit(1'b1, 1'b0, 1'b0, 1'b0, o);
    for (int i = 0; i < n; i++) begin
      tckBit(1'b0, 1'b1, 1'b0, din[i], o);
      dout[i] = o;
    end
    tckBit(1'b0, 1'b0, 1'b1, 1'b0, o);
  endtask : dr

  // follows go during a run, checks start order and holding
  task automatic runWatch(input logic [7:0] a, input logic par);
    logic [7:0] prev;
    prev = 8'h00;
    for (int i = 0; i < 500 && !(prev != 8'h00 && engineGo === 8'h00); i++) begin
      if (engineGo !== prev && engineGo !== 8'h00) begin
        chk("engineGo", par ? a : prev | (a & ~prev & -(a & ~prev)), engineGo);
        prev = engineGo;
      end
      tick(1);
    end
    chk("allStarted", a, prev);
  endtask : runWatch

  task automatic test_done;
    $display("checks %0d failures %0d", nChecks, nFail);
    if (nFail == 0 && nChecks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : test_done

  // watchdog
  initial begin
    tick(80000);
    nFail++;
    test_done();
  end

  // main sequence
  initial begin
    logic [7:0] act, skip;
    logic [1:0] md;
    core_clk = 1'b0;
    nrst = 1'b0;
    jtagTck = 1'b0;
    jtagTdi = 1'b0;
    jtagInstr = 8'h00;
    jtagCaptureDr = 1'b0;
    jtagShiftDr = 1'b0;
    jtagUpdateDr = 1'b0;
    mfgScanMode = 1'b0;
    firstPowerDone = 1'b0;
    warmPhaseOne = 1'b0;
    swRunReq = 1'b0;
    swArrayInit = 1'b0;
    rnd = 32'hE442;
    dly = 32'h0;
    stuck = 8'h00;
    rnd = xs(rnd);
    coreAvail = rnd[7:0] | 8'h11;
    coreDisable = rnd[15:8] & 8'hEE;
    coreShadowData = '0;
    tagShadowData = '0;
    act = coreAvail & ~coreDisable;
    tick(20);
    nrst <= 1'b1;
    tick(3);
    chk("goAtReset", 8'h00, engineGo);
    // power-on array-init pass, parallel by default
    firstPowerDone <= 1'b1;
    runWatch(act, 1'b1);
    chk("powerDone", 1'b1, selfTestComplete);
    chk("powerInit", 1'b1, runArrayInit);
    $display("test power pass done");
    // jtag runs with random skip mask and program bit, serial and parallel in turn
    for (int t = 0; t < 4; t++) begin
      rnd = xs(rnd);
      dly <= rnd;
      skip = (t == 0) ? 8'h00 : rnd[7:0];
      if ((~skip & act) == 8'h00) skip = 8'h00;
      md = {rnd[9], t[0]};
      dr(INSTR_SKIP, 8, skip, got);
      dr(INSTR_SKIP, 8, skip, got);
      chk("skipMask", skip, got[7:0]);
      dr(INSTR_MODE, 8, {6'h00, md}, got);
      tick(4);
      chk("progAccess", md[1], progAccess);
      // watch from before the start so that short runs are not missed
      fork
        dr(INSTR_START, 0, '0, got);
        runWatch(~skip & act, md[0]);
      join
      dr(INSTR_DONE_RD, 8, 64'hFF, got);
      chk("doneFlags", ~skip & act, got[7:0]);
      $display("test jtag run %0d done", t);
    end
    // abort while every engine stalls
    stuck <= 8'hFF;
    dr(INSTR_MODE, 8, 64'h1, got);
    dr(INSTR_START, 0, '0, got);
    chk("goBeforeAbort", ~skip & act, engineGo);
    dr(INSTR_ABORT, 0, '0, got);
    tick(20);
    chk("goAfterAbort", 8'h00, engineGo);
    $display("test abort done");
    // software array-init run between warm phases, ended by timeout
    swRunReq <= 1'b1;
    swArrayInit <= 1'b1;
    warmPhaseOne <= 1'b1;
    for (int i = 0; i < 50 && engineGo === 8'h00; i++) tick(1);
    chk("warmGo", ~skip & act, engineGo);
    chk("warmInit", 1'b1, runArrayInit);
    for (int i = 0; i < 60 && selfTestComplete !== 1'b1; i++) tick(1);
    tick(2);
    chk("timeoutDone", 1'b1, selfTestComplete);
    chk("timeoutGo", 8'h00, engineGo);
    warmPhaseOne <= 1'b0;
    swRunReq <= 1'b0;
    stuck <= 8'h00;
    mfgScanMode <= 1'b1;
    tick(6);
    chk("testMode", 1'b1, engineTestMode);
    $display("test warm run done");
    // shadow chains
    rnd = xs(rnd);
    tagShadowData <= {rnd, xs(rnd)};
    coreShadowData <= {xs(rnd), rnd};
    dr(INSTR_TAG, 64, {xs(rnd), rnd}, got);
    chk("tagChain", tagShadowData, got);
    dr(INSTR_TAG, 64, ~got, got);
    chk("tagReadOnly", tagShadowData, got);
    md = rnd[1:0];
    dr(INSTR_THREAD0 + {5'h00, rnd[2:0]}, $countones(coreAvail) * 8, ~got, got);
    chk("threadSel", rnd[2:0], shadowThreadSel);
    chk("coreChain", coreStream(coreAvail, coreShadowData), got);
    jtagInstr <= INSTR_DIAG;
    tick(4);
    tckBit(1'b0, 1'b1, 1'b0, 1'b0, got[0]);
    tick(3);
    chk("diagScanEn", 8'hFF, coreScanEnable);
    chk("diagSel", 1'b1, diagChainSel);
    // serial chain instruction keeps scan enable, drops the diag select
    jtagInstr <= INSTR_SERIAL;
    tick(4);
    chk("serialScanEn", 8'hFF, coreScanEnable);
    chk("diagSelOff", 1'b0, diagChainSel);
    jtagShiftDr <= 1'b0;
    tick(4);
    chk("scanEnOff", 8'h00, coreScanEnable);
    $display("test shadow scan done");
    test_done();
  end
endmodule : selftest_sequencer_shadow_scan_tb
`default_nettype wire
